// >>> inc/ppm_pkg.sv
// ppm_pkg: constants shared by the printer port pin logic
// assumes a single 10 MHz clock and a byte-wide register port
package ppm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;
  localparam logic [2:0]  OFF_DATA = 3'h0;
  localparam logic [2:0]  OFF_STAT = 3'h1;
  localparam logic [2:0]  OFF_CTRL = 3'h2;
  localparam logic [2:0]  OFF_ISTA = 3'h3;
  localparam logic [2:0]  OFF_IMSK = 3'h4;
  localparam logic [2:0]  OFF_MODE = 3'h5;
  localparam logic [2:0]  OFF_EPPD = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_STROBE = 0;
  localparam int unsigned CTL_LFEED  = 1;
  localparam int unsigned CTL_RESET  = 2;
  localparam int unsigned CTL_SELECT = 3;
  localparam int unsigned CTL_IRQEN  = 4;
  localparam int unsigned CTL_DIR    = 5;
  localparam int unsigned CTL_W      = 6;
  localparam int unsigned ST_NBUSY   = 7;
  localparam int unsigned ST_ACCEPT  = 6;
  localparam int unsigned ST_EMPTY   = 5;
  localparam int unsigned ST_ONLINE  = 4;
  localparam int unsigned ST_FAULT   = 3;
  localparam int unsigned ST_TMO     = 0;
  localparam int unsigned EV_ACCEPT  = 0;
  localparam int unsigned EV_FAULT   = 1;
  localparam int unsigned EV_TMO     = 2;
  localparam int unsigned EV_W       = 3;
  localparam int unsigned MODE_EPP   = 0;
  localparam int unsigned SY_BUSY    = 0;
  localparam int unsigned SY_ACCEPT  = 1;
  localparam int unsigned SY_EMPTY   = 2;
  localparam int unsigned SY_ONLINE  = 3;
  localparam int unsigned SY_FAULT   = 4;
  localparam int unsigned SY_W       = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [EV_W-1:0]  IRQ_RST  = 3'h0;
  localparam logic [SY_W-1:0]  SYNC_RST = 5'h1A; // idle: accepted, online, fault lines high

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned EPP_TIMEOUT_NS = 10000;
  localparam int unsigned EPP_TIMEOUT_CYC = EPP_TIMEOUT_NS / CLK_PERIOD_NS; // longest wait, rounded down
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {EPP_IDLE, EPP_WAIT} ppm_epp_e;

endpackage : ppm_pkg

// >>> hw/ppm_sync.sv
// ppm_sync: two-stage synchroniser for the peripheral status inputs
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps
`default_nettype none
module ppm_sync
  import ppm_pkg::*;
#(
  parameter int unsigned            WIDTH   = SY_W,
  parameter logic [SY_W-1:0]        RST_VAL = SYNC_RST
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  if (WIDTH < 1 || WIDTH > SY_W) begin : g_chk
    $error("ppm_sync: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ppm_sync_s;

  ppm_sync_s q, d;

  // first stage feeds only the second stage
  always_comb begin
    d        = q;
    d.meta   = d_i; // R15
    d.stable = q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{meta: RST_VAL[WIDTH-1:0], stable: RST_VAL[WIDTH-1:0]};
    end else begin
      q <= d;
    end
  end

  assign q_o = q.stable;

  a_sync_two_stage: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    !$past(rst_i, 1) && !$past(rst_i, 2) |-> q_o == $past(d_i, 2))
    else $error("synchroniser output is not the input two cycles back");

endmodule : ppm_sync
`default_nettype wire

// >>> hw/ppm_port.sv
// ppm_port: standard and enhanced mode printer port pin logic with register port
// assumes all inputs sampled on clk_i; peripheral status lines are asynchronous
// and pass through ppm_sync; the host side waits on the register port only while an enhanced access is stretched
//
// Operation
// R1 - select output low while control bit 3 is set
// R2 - reset output follows control bit 2 directly, low resets printer
// R3 - line feed output low while control bit 1 is set
// R4 - data latch output low while control bit 0 is set
// R5 - software pulses control bit 0 to latch data into printer
// R6 - status bit 7 reads inverse of busy input
// R7 - status bit 6 reads accepted input unchanged
// R8 - printer drives accepted line low when it takes the data
// R9 - status bit 5 reads media empty input directly
// R10 - status bit 4 reads online input directly
// R11 - status bit 3 reads fault input directly
// R12 - eight port data lines form a two-way bus
// R13 - enhanced mode pulls host ready low to stretch access, else released
// R14 - second interrupt output gated by control bit 4
// R15 - status inputs pass a two-stage synchroniser before being read
`timescale 1ns/1ps
`default_nettype none
module ppm_port
  import ppm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = EPP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rd_data_o,
  // printer control outputs
  output logic                   printer_select_out_n_o,
  output logic                   printer_reset_out_n_o,
  output logic                   line_feed_out_n_o,
  output logic                   data_latch_pulse_n_o,
  // printer status inputs
  input  wire logic              busy_i,
  input  wire logic              printer_accepted_n_i,
  input  wire logic              media_empty_i,
  input  wire logic              printer_online_i,
  input  wire logic              printer_fault_n_i,
  // port data lines
  input  wire logic [DATA_W-1:0] port_data_lines_i,
  output logic      [DATA_W-1:0] port_data_lines_o,
  output logic                   port_data_lines_oe_o,
  // host bus ready, open drain
  output logic                   host_ready_o,
  output logic                   host_ready_oe_o,
  // interrupts
  output logic                   irq_o,
  output logic                   port_irq_second_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << CNT_W)) begin : g_chk
    $error("ppm_port: TIMEOUT_CYC out of range");
  end

  localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYC - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CTL_W-1:0]  ctrl;
    logic              epp_en;
    logic [EV_W-1:0]   irq_stat;
    logic [EV_W-1:0]   irq_mask;
    logic [DATA_W-1:0] rd_data;
    ppm_epp_e          epp_st;
    logic [CNT_W-1:0]  cnt;
    logic [SY_W-1:0]   prev;
  } ppm_state_s;

  localparam ppm_state_s STATE_RST = '{
    data:     '0,
    ctrl:     CTRL_RST,
    epp_en:   1'b0,
    irq_stat: IRQ_RST,
    irq_mask: IRQ_RST,
    rd_data:  '0,
    epp_st:   EPP_IDLE,
    cnt:      '0,
    prev:     SYNC_RST
  };

  ppm_state_s q, d;

  // address match used by several decodes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // status input synchroniser
  // ----------------------------------------------------------------
  logic [SY_W-1:0] sync_raw;
  logic [SY_W-1:0] sy;

  assign sync_raw = {printer_fault_n_i, printer_online_i, media_empty_i,
                     printer_accepted_n_i, busy_i};

  ppm_sync #(
    .WIDTH   (SY_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sync_raw), // R15
    .q_o   (sy)
  );

  // ----------------------------------------------------------------
  // events and decodes
  // ----------------------------------------------------------------
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   clr;
  logic              epp_start;
  logic              tmo_ev;
  logic [DATA_W-1:0] status;

  // falling edges of synchronised lines; the edge detector reads stage two only
  assign tmo_ev    = (q.epp_st == EPP_WAIT) && !sy[SY_BUSY] && (q.cnt == TO_LAST);
  assign ev[EV_ACCEPT] = q.prev[SY_ACCEPT] && !sy[SY_ACCEPT];
  assign ev[EV_FAULT]  = q.prev[SY_FAULT] && !sy[SY_FAULT];
  assign ev[EV_TMO]    = tmo_ev;
  assign clr       = (wr_i && hit(addr_i, OFF_ISTA)) ? wr_data_i[EV_W-1:0] : '0;
  assign epp_start = q.epp_en && (wr_i || rd_i) && hit(addr_i, OFF_EPPD);

  // status byte; reserved bits 2:1 read as zero
  always_comb begin
    status            = '0;
    status[ST_NBUSY]  = !sy[SY_BUSY];   // R6
    status[ST_ACCEPT] = sy[SY_ACCEPT];  // R7
    status[ST_EMPTY]  = sy[SY_EMPTY];   // R9
    status[ST_ONLINE] = sy[SY_ONLINE];  // R10
    status[ST_FAULT]  = sy[SY_FAULT];   // R11
    status[ST_TMO]    = q.irq_stat[EV_TMO];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.rd_data = '0; // read data stand for one cycle only
    d.prev    = sy;
    // sticky events: a set in the clearing cycle wins
    d.irq_stat = (q.irq_stat & ~clr) | ev;

    // register writes
    if (wr_i) begin
      case (addr_i)
        OFF_DATA: d.data     = wr_data_i; // R12
        OFF_CTRL: d.ctrl     = wr_data_i[CTL_W-1:0]; // R5
        OFF_IMSK: d.irq_mask = wr_data_i[EV_W-1:0];
        OFF_MODE: d.epp_en   = wr_data_i[MODE_EPP];
        OFF_EPPD: begin
          if (q.epp_en) begin
            d.data = wr_data_i;
          end
        end
        default: ;
      endcase
    end

    // register reads, answered in the next cycle
    if (rd_i) begin
      case (addr_i)
        OFF_DATA: d.rd_data = q.ctrl[CTL_DIR] ? port_data_lines_i : q.data; // R12
        OFF_STAT: d.rd_data = status;
        OFF_CTRL: d.rd_data = DATA_W'(q.ctrl);
        OFF_ISTA: d.rd_data = DATA_W'(q.irq_stat);
        OFF_IMSK: d.rd_data = DATA_W'(q.irq_mask);
        OFF_MODE: d.rd_data = DATA_W'(q.epp_en);
        OFF_EPPD: d.rd_data = q.epp_en ? port_data_lines_i : '0;
        default:  d.rd_data = '0;
      endcase
    end

    // enhanced access stretch: hold the host off until the peripheral
    // signals ready on busy, or give up after the timeout
    case (q.epp_st)
      EPP_IDLE: begin
        d.cnt = '0;
        if (epp_start) begin
          d.epp_st = EPP_WAIT; // R13
        end
      end
      EPP_WAIT: begin
        d.cnt = q.cnt + CNT_W'(1);
        if (sy[SY_BUSY] || tmo_ev || !q.epp_en) begin
          d.epp_st = EPP_IDLE;
          d.cnt    = '0;
        end
      end
      default: begin
        d.epp_st = EPP_IDLE;
        d.cnt    = '0;
      end
    endcase
  end

  // single register for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // control lines come straight off the control flops
  assign printer_select_out_n_o = !q.ctrl[CTL_SELECT]; // R1
  assign printer_reset_out_n_o  = q.ctrl[CTL_RESET];   // R2
  assign line_feed_out_n_o      = !q.ctrl[CTL_LFEED];  // R3
  assign data_latch_pulse_n_o   = !q.ctrl[CTL_STROBE]; // R4
  assign rd_data_o              = q.rd_data;

  // data lines driven unless the direction bit turns them round
  assign port_data_lines_o    = q.data;             // R12
  assign port_data_lines_oe_o = !q.ctrl[CTL_DIR];   // R12

  // ready is only ever pulled low; the pull-up makes it high otherwise
  assign host_ready_o    = 1'b0;
  assign host_ready_oe_o = (q.epp_st == EPP_WAIT);  // R13

  // level interrupt; the second output is also gated by control bit 4
  assign irq_o             = |(q.irq_stat & q.irq_mask);
  assign port_irq_second_o = irq_o && q.ctrl[CTL_IRQEN]; // R14

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_select_out_inv: assert property ( // R1
    wr_i && hit(addr_i, OFF_CTRL) |=> printer_select_out_n_o == !$past(wr_data_i[CTL_SELECT]))
    else $error("select output is not the inverse of control bit 3");

  a_reset_out_direct: assert property ( // R2
    wr_i && hit(addr_i, OFF_CTRL) |=> printer_reset_out_n_o == $past(wr_data_i[CTL_RESET]))
    else $error("reset output does not follow control bit 2");

  a_line_feed_inv: assert property ( // R3
    wr_i && hit(addr_i, OFF_CTRL) |=> line_feed_out_n_o == !$past(wr_data_i[CTL_LFEED]))
    else $error("line feed output is not the inverse of control bit 1");

  a_latch_pulse_inv: assert property ( // R4
    wr_i && hit(addr_i, OFF_CTRL) |=> data_latch_pulse_n_o == !$past(wr_data_i[CTL_STROBE]))
    else $error("latch output is not the inverse of control bit 0");

  a_busy_read_inv: assert property ( // R6
    rd_i && hit(addr_i, OFF_STAT) && !$past(rst_i, 3) |=> rd_data_o[ST_NBUSY] == !$past(busy_i, 3))
    else $error("status bit 7 is not inverse busy");

  a_accept_read_direct: assert property ( // R7
    rd_i && hit(addr_i, OFF_STAT) && !$past(rst_i, 3)
    |=> rd_data_o[ST_ACCEPT] == $past(printer_accepted_n_i, 3))
    else $error("status bit 6 does not read the accepted input");

  a_empty_read_direct: assert property ( // R9
    rd_i && hit(addr_i, OFF_STAT) && !$past(rst_i, 3) |=> rd_data_o[ST_EMPTY] == $past(media_empty_i, 3))
    else $error("status bit 5 does not read media empty");

  a_online_read_direct: assert property ( // R10
    rd_i && hit(addr_i, OFF_STAT) && !$past(rst_i, 3) |=> rd_data_o[ST_ONLINE] == $past(printer_online_i, 3))
    else $error("status bit 4 does not read online");

  a_fault_read_direct: assert property ( // R11
    rd_i && hit(addr_i, OFF_STAT) && !$past(rst_i, 3) |=> rd_data_o[ST_FAULT] == $past(printer_fault_n_i, 3))
    else $error("status bit 3 does not read the fault input");

  a_data_drive_turn: assert property ( // R12
    wr_i && hit(addr_i, OFF_CTRL) |=> port_data_lines_oe_o == !$past(wr_data_i[CTL_DIR]))
    else $error("data line enable does not follow direction bit");

  a_ready_stretch: assert property ( // R13
    epp_start && q.epp_st == EPP_IDLE |=> host_ready_oe_o && !host_ready_o)
    else $error("enhanced access did not stretch the host cycle");

  a_ready_released: assert property ( // R13
    !q.epp_en |=> !host_ready_oe_o)
    else $error("ready pulled low outside enhanced mode");

  a_irq2_gated: assert property ( // R14
    wr_i && hit(addr_i, OFF_CTRL) && !wr_data_i[CTL_IRQEN] |=> !port_irq_second_o)
    else $error("second interrupt asserted while disabled");

  // write data and read-back paths
  a_data_drive_value: assert property ( // R12
    wr_i && hit(addr_i, OFF_DATA) |=> port_data_lines_o == $past(wr_data_i))
    else $error("data lines do not show the written byte");

  a_data_read_pins: assert property ( // R12
    rd_i && hit(addr_i, OFF_DATA) && q.ctrl[CTL_DIR] |=> rd_data_o == $past(port_data_lines_i))
    else $error("turned-round data read does not return the pins");

  a_ctrl_read_back: assert property ( // R5
    rd_i && hit(addr_i, OFF_CTRL) |=> rd_data_o == DATA_W'($past(q.ctrl)))
    else $error("control read does not return the control bits");

  // an enhanced data write with the mode off must leave the latch alone
  a_eppd_refused: assert property ( // R13
    wr_i && hit(addr_i, OFF_EPPD) && !q.epp_en |=> $stable(port_data_lines_o))
    else $error("enhanced data write taken while the mode is off");

  // the stretch always ends: on busy from the peripheral or on the counter
  a_ready_busy_end: assert property ( // R13
    host_ready_oe_o && sy[SY_BUSY] |=> !host_ready_oe_o)
    else $error("ready still pulled low after the peripheral answered");

  a_ready_timeout: assert property ( // R13
    host_ready_oe_o && !sy[SY_BUSY] && q.cnt == TO_LAST |=> !host_ready_oe_o && q.irq_stat[EV_TMO])
    else $error("stretch not released with its flag at the timeout");

  // a falling accept must leave its flag set even when cleared in that cycle
  a_accept_sets_flag: assert property ( // R7
    q.prev[SY_ACCEPT] && !sy[SY_ACCEPT] |=> q.irq_stat[EV_ACCEPT])
    else $error("accept edge did not set its flag");

  // main scenarios worth seeing in a run
  c_latch_pulse: cover property (
    $fell(data_latch_pulse_n_o) ##[1:20] $rose(data_latch_pulse_n_o));
  c_epp_timeout: cover property (host_ready_oe_o ##1 tmo_ev);
  c_accept_irq: cover property (ev[EV_ACCEPT] ##1 irq_o);
  c_fault_event: cover property (ev[EV_FAULT] ##1 q.irq_stat[EV_FAULT]);
  c_dir_read: cover property (rd_i && hit(addr_i, OFF_DATA) && q.ctrl[CTL_DIR]);

endmodule : ppm_port
`default_nettype wire

// >>> tb/ppm_printer_model.sv
// ppm_printer_model: behavioural printer on the far side of the port pins
// assumes the strobe is slow against clk_i, so it is sampled as a level
`timescale 1ns/1ps
`default_nettype none
module ppm_printer_model #(
  parameter int         BUSY_CYC = 12,
  parameter logic [7:0] REV_DATA = 8'hC3
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // lines from the port
  input  wire logic       data_latch_pulse_n_i,
  input  wire logic [7:0] port_data_lines_i,
  // lines to the port
  output logic            busy_o,
  output logic            printer_accepted_n_o,
  output logic      [7:0] drive_data_o,
  // byte taken, for the bench to judge
  output logic      [7:0] latched_o
);
  logic strobe_q;
  int   cnt_q;

  // value offered on the data lines once the port turns them round
  assign drive_data_o = REV_DATA;

  // ------------------------------------------------------------
  // take the byte on the falling strobe, stay busy, then acknowledge
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    strobe_q <= data_latch_pulse_n_i;
    if (rst_i) begin
      busy_o               <= 1'b0;
      printer_accepted_n_o <= 1'b1;
      cnt_q                <= 0;
      latched_o            <= 8'h00;
    end else if (strobe_q && !data_latch_pulse_n_i) begin
      latched_o <= port_data_lines_i;
      busy_o    <= 1'b1;
      cnt_q     <= 1;
    end else if (cnt_q != 0) begin
      cnt_q <= (cnt_q == BUSY_CYC + 2) ? 0 : cnt_q + 1;
      // ack low for two cycles, busy falls when it ends
      if (cnt_q == BUSY_CYC) printer_accepted_n_o <= 1'b0;
      if (cnt_q == BUSY_CYC + 2) begin
        printer_accepted_n_o <= 1'b1;
        busy_o               <= 1'b0;
      end
    end
  end
endmodule : ppm_printer_model
`default_nettype wire

// >>> tb/printer_port_pin_mapping_tb.sv
// printer_port_pin_mapping_tb: self-checking bench for ppm_port
// assumes ppm_pkg compiled first and the printer model beside the port
`timescale 1ns/1ps
`default_nettype none
module printer_port_pin_mapping_tb;
  import ppm_pkg::*;
  logic       clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00, rd_data_o, pd_o, pd_w, pd_m, latched;
  logic       sel_n, rst_n, lf_n, lat_n, oe, busy, acc_n, rdy, rdy_oe, irq, irq2;
  logic       empty = 1'b0, online = 1'b1, fault_n = 1'b1;
  int         fail_count = 0, cmp_count = 0;

  always #50 clk_i = ~clk_i;
  // the data wire: port drives when enabled, else the printer does
  assign pd_w = oe ? pd_o : pd_m;

  ppm_port #(.TIMEOUT_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .printer_select_out_n_o(sel_n), .printer_reset_out_n_o(rst_n), .line_feed_out_n_o(lf_n),
    .data_latch_pulse_n_o(lat_n), .busy_i(busy), .printer_accepted_n_i(acc_n),
    .media_empty_i(empty), .printer_online_i(online), .printer_fault_n_i(fault_n),
    .port_data_lines_i(pd_w), .port_data_lines_o(pd_o), .port_data_lines_oe_o(oe),
    .host_ready_o(rdy), .host_ready_oe_o(rdy_oe), .irq_o(irq), .port_irq_second_o(irq2));

  ppm_printer_model prn (.clk_i(clk_i), .rst_i(rst_i), .data_latch_pulse_n_i(lat_n),
    .port_data_lines_i(pd_w), .busy_o(busy), .printer_accepted_n_o(acc_n),
    .drive_data_o(pd_m), .latched_o(latched));

  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("ctl pins", 8'h0B, {4'h0, sel_n, rst_n, lf_n, lat_n});
    chk("rdy oe irq", 8'h00, {5'h0, rdy_oe, irq, irq2});
  endtask : t_reset
  // control bits 0 to 3 each alone, then all clear
  task automatic t_ctrl;
    logic [7:0] v;
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      v = (i < 4) ? (8'h01 << i) : 8'h00;
      wr(OFF_CTRL, v);
      settle(1);
      chk("ctl pins", {4'h0, ~v[3], v[2], ~v[1], ~v[0]}, {4'h0, sel_n, rst_n, lf_n, lat_n});
      rd(OFF_CTRL, d);
      chk("ctl read", v, d);
    end
  endtask : t_ctrl
  // a byte strobed out, busy seen, accept raises the gated interrupt
  task automatic t_print;
    logic [7:0] d;
    int         n;
    wr(OFF_DATA, 8'h5A);
    settle(1);
    chk("data pins", 8'h5A, pd_w);
    chk("data oe", 8'h01, {7'h0, oe});
    wr(OFF_IMSK, 8'h01);
    wr(OFF_CTRL, 8'h11);
    wr(OFF_CTRL, 8'h10);
    settle(4);
    rd(OFF_STAT, d);
    chk("stat busy", 8'h00, {7'h0, d[7]});
    n = 0;
    while (acc_n !== 1'b0 && n < 40) begin
      settle(1);
      n++;
    end
    settle(1);
    rd(OFF_STAT, d);
    chk("stat accept", 8'h00, {7'h0, d[6]});
    settle(3);
    chk("latched", 8'h5A, latched);
    chk("irq pair", 8'h03, {6'h0, irq, irq2});
    wr(OFF_CTRL, 8'h00);
    settle(1);
    chk("irq pair", 8'h02, {6'h0, irq, irq2});
    wr(OFF_ISTA, 8'h01);
    settle(1);
    chk("irq pair", 8'h00, {6'h0, irq, irq2});
  endtask : t_print
  // static status lines both ways; fault event stays masked
  task automatic t_status;
    logic [7:0] d;
    @(posedge clk_i);
    empty   <= 1'b1;
    online  <= 1'b0;
    settle(4);
    rd(OFF_STAT, d);
    chk("stat bits", 8'h1D, {3'h0, d[7:3]});
    @(posedge clk_i);
    empty   <= 1'b0;
    online  <= 1'b1;
    fault_n <= 1'b0;
    settle(4);
    rd(OFF_STAT, d);
    chk("stat bits", 8'h1A, {3'h0, d[7:3]});
    chk("masked irq", 8'h00, {7'h0, irq});
    rd(OFF_ISTA, d);
    chk("fault event", 8'h02, d & 8'h02);
    wr(OFF_ISTA, 8'h02);
    fault_n <= 1'b1;
    rd(OFF_ISTA, d);
    chk("fault clear", 8'h00, d);
  endtask : t_status
  localparam logic [2:0] OFF_7 = 3'h7;
  // turned round: the port reads the printer's byte
  task automatic t_dir;
    logic [7:0] d;
    wr(OFF_CTRL, 8'h20);
    settle(3);
    chk("data oe", 8'h00, {7'h0, oe});
    rd(OFF_DATA, d);
    chk("data in", 8'hC3, d);
    settle(1);
    chk("rd idle", 8'h00, rd_data_o);
    rd(OFF_7, d);
    chk("unmapped", 8'h00, d);
    wr(OFF_CTRL, 8'h00);
  endtask : t_dir
  // printer never busy, so the stretch ends on the timeout
  task automatic t_stretch;
    logic [7:0] d;
    int         n;
    wr(OFF_MODE, 8'h01);
    wr(OFF_EPPD, 8'h33);
    #1;
    chk("ready pull", 8'h02, {6'h0, rdy_oe, rdy});
    n = 0;
    while (rdy_oe !== 1'b0 && n < 20) begin
      settle(1);
      n++;
    end
    chk("stretch end", 8'h08, 8'(n));
    rd(OFF_ISTA, d);
    chk("timeout event", 8'h04, d & 8'h04);
    wr(OFF_ISTA, 8'h04);
    wr(OFF_MODE, 8'h00);
  endtask : t_stretch

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    t_reset();
    t_ctrl();
    t_print();
    t_status();
    t_dir();
    t_stretch();
    end_sim();
  end
  // whole run is about 110 cycles; allow over twenty-five times that
  initial begin
    #(3000 * 100);
    fail_count++;
    end_sim();
  end
endmodule : printer_port_pin_mapping_tb
`default_nettype wire
